// ==== hw/synth_ctrl_pkg.sv ====
// shared constants for the synthesizer divider and calibration control block
package synth_ctrl_pkg;

  // register file layout: printed offsets are indices, byte address = 4 * index
  localparam int REG_COUNT = 15;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 4;

  localparam int IX_SOFT_RESET = 0;
  localparam int IX_CLK_SOURCE = 1;
  localparam int IX_REFDIV_LO = 2;
  localparam int IX_REFDIV_HI_OUTDIV = 3;
  localparam int IX_PRESCALE_LO = 4;
  localparam int IX_PRESCALE_HI = 5;
  localparam int IX_PUMP = 6;
  localparam int IX_SYNTH_EN = 7;
  localparam int IX_FILTER_RES = 8;
  localparam int IX_FILTER_CAP3 = 9;
  localparam int IX_FILTER_CAP1 = 10;
  localparam int IX_FILTER_CAP2 = 11;
  localparam int IX_OUT_EN = 12;
  localparam int IX_CAL_TRIG = 13;
  localparam int IX_CLK_GATE = 14;

  localparam logic [7:0] REG_INDEX [REG_COUNT] = '{
    8'h00, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59,
    8'h5A, 8'h5B, 8'h5C, 8'h5D, 8'h5F, 8'h6B, 8'h6D};
  localparam logic [7:0] REG_WMASK [REG_COUNT] = '{
    8'h01, 8'h01, 8'hFF, 8'hF3, 8'hFF, 8'h0F, 8'h0F, 8'h03,
    8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h03, 8'h01, 8'h0F};
  localparam logic [7:0] REG_RESET [REG_COUNT] = '{
    8'h00, 8'h00, 8'h01, 8'h10, 8'h01, 8'h00, 8'h04, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] STATUS_INDEX = 8'hD1;

  // field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int CLK_SOURCE_BIT = 0;
  localparam int REFDIV_HI_LSB = 0;
  localparam int OUTDIV_LSB = 4;
  localparam int SYNTH_EN_BIT = 0;
  localparam int REFDIV_EN_BIT = 1;
  localparam int OUT_EN_BIT = 0;
  localparam int BIAS_EN_BIT = 1;
  localparam int CAL_TRIG_BIT = 0;
  localparam int DATA_CLK_DLY_LSB = 0;
  localparam int CLK_GATE_BIT = 3;
  localparam int STAT_CAL_DONE_BIT = 0;
  localparam int STAT_DRIFT_LOW_BIT = 1;
  localparam int STAT_DRIFT_HIGH_BIT = 2;

  localparam logic [8:0] PUMP_STEP_UA = 9'h019;

  // calibration timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CAL_TIME_NS = 1000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CAL_LAST = 8'(CAL_CYCLES - 1);

  typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_e;

endpackage : synth_ctrl_pkg

// ==== hw/tick_divider.sv ====
// integer divider of a one-cycle tick stream
`timescale 1ns/1ps
module tick_divider #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic enable,
  input wire logic [W-1:0] divisor,
  // ticks in and out
  input wire logic tick,
  output logic pulse_q
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic [W-1:0] last;
  logic pulse_d;

  always_comb begin
    // zero divisor behaves as one
    last = (divisor == '0) ? '0 : divisor - W'(1);
    count_d = count_q;
    pulse_d = 1'b0;
    if (!enable) begin
      count_d = '0;
    end else if (tick) begin
      if (count_q >= last) begin
        count_d = '0;
        pulse_d = 1'b1;
      end else begin
        count_d = count_q + W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      count_q <= count_d;
      pulse_q <= pulse_d;
    end
  end

endmodule : tick_divider

// ==== hw/synth_clock_control.sv ====
// synthesizer divider, output gating and calibration control behind ahb-lite
// Functional notes
// - reference edges are divided by a 10-bit value, 1 to 1023.
// - oscillator ticks in the feedback path are divided by a 12-bit value.
// - sampling clock is oscillator ticks divided by the 4-bit output divider.
// - 4-bit pump code scales bias by 25 uA per step, up to 375 uA.
// - 5-bit loop filter codes sit at 0x5A, 0x5B, 0x5C and 0x5D.
// - divider settings live at offsets 0x54 through 0x57.
// - calibration starts on trigger bit toggle or on soft reset exit, not on entering soft reset.
// - calibration runs when soft reset mode is exited.
// - calibration status bit at 0xD1 shows completion.
// - two drift flags at 0xD1 report oscillator drifting low or high.
// - synthesizer and reference divider enables both sit at 0x59.
// - synthesizer output and bias enables both sit at 0x5F.
// - output clock enable at 0x6D passes or withholds the synthesized clock.
// - 3-bit field at 0x6D delays the data clock by oscillator ticks.
// - clock source select one takes the core clock from the synthesizer.
// - after reset the core clock comes straight from the external input.
`timescale 1ns/1ps
module synth_clock_control (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // clock sources and analog monitors
  input wire logic ref_clk_in,
  input wire logic osc_tick_in,
  input wire logic osc_drift_low_in,
  input wire logic osc_drift_high_in,
  // divided clocks
  output logic comparator_ref_pulse,
  output logic feedback_pulse,
  output logic core_sample_pulse,
  output logic output_data_clock,
  // analog settings
  output logic [3:0] pump_current_code,
  output logic [8:0] pump_bias_ua,
  output logic [4:0] filter_resistor_code,
  output logic [4:0] filter_cap_one_code,
  output logic [4:0] filter_cap_two_code,
  output logic [4:0] filter_cap_three_code,
  // enables and calibration
  output logic synth_enable,
  output logic ref_divider_enable,
  output logic synth_out_enable,
  output logic synth_bias_enable,
  output logic soft_reset_active,
  output logic cal_busy
);

  // bus and register state
  logic [7:0] cfg_q [synth_ctrl_pkg::REG_COUNT];
  logic [7:0] cfg_d [synth_ctrl_pkg::REG_COUNT];
  logic wr_pend_q;
  logic wr_pend_d;
  logic [synth_ctrl_pkg::IDX_W-1:0] wr_idx_q;
  logic [synth_ctrl_pkg::IDX_W-1:0] wr_idx_d;
  logic [31:0] hrdata_d;
  logic addr_take;
  logic reg_hit;
  logic [synth_ctrl_pkg::IDX_W-1:0] hit_idx;
  logic stat_hit;
  logic [7:0] wr_byte;
  logic [7:0] wr_merged;

  // calibration and status state
  synth_ctrl_pkg::cal_state_e cal_state_q;
  synth_ctrl_pkg::cal_state_e cal_state_d;
  logic [7:0] cal_cnt_q;
  logic [7:0] cal_cnt_d;
  logic cal_busy_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic trig_change;
  logic soft_exit;
  logic cal_start;

  // clock path state
  logic ref_prev_q;
  logic ref_edge;
  logic synth_pulse;
  logic gated_pulse;
  logic core_sample_d;
  logic [2:0] delay_cnt_q;
  logic [2:0] delay_cnt_d;
  logic delay_run_q;
  logic delay_run_d;
  logic data_clock_d;
  logic [8:0] pump_bias_d;
  logic [9:0] ref_div_value;
  logic [11:0] prescale_value;
  logic [3:0] output_div_value;
  logic [2:0] dly_value;
  logic clk_source_sel;
  logic clk_gate_en;

  // ---------------- ahb-lite slave ----------------
  always_comb begin
    addr_take = hsel && htrans[1] && hready;
    reg_hit = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < synth_ctrl_pkg::REG_COUNT; i++) begin
      if (haddr[11:2] == {2'b00, synth_ctrl_pkg::REG_INDEX[i]}) begin
        reg_hit = 1'b1;
        hit_idx = synth_ctrl_pkg::IDX_W'(i);
      end
    end
    stat_hit = haddr[11:2] == {2'b00, synth_ctrl_pkg::STATUS_INDEX};
    wr_byte = hwdata[7:0];
    wr_merged = (cfg_q[wr_idx_q] & ~synth_ctrl_pkg::REG_WMASK[wr_idx_q])
              | (wr_byte & synth_ctrl_pkg::REG_WMASK[wr_idx_q]);
    // unmapped addresses and writes to the status word are dropped
    wr_pend_d = addr_take && hwrite && reg_hit;
    wr_idx_d = hit_idx;
    hrdata_d = hrdata;
    if (addr_take && !hwrite) begin
      hrdata_d = '0;
      if (reg_hit) begin
        // bypass a write still in its data phase
        if (wr_pend_q && wr_idx_q == hit_idx) begin
          hrdata_d[7:0] = wr_merged;
        end else begin
          hrdata_d[7:0] = cfg_q[hit_idx];
        end
      end else if (stat_hit) begin
        hrdata_d[7:0] = status_q;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      hrdata <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // one configuration byte per mapped offset
  for (genvar g = 0; g < synth_ctrl_pkg::REG_COUNT; g++) begin : g_cfg
    always_comb begin
      cfg_d[g] = cfg_q[g];
      if (wr_pend_q && wr_idx_q == synth_ctrl_pkg::IDX_W'(g)) begin
        cfg_d[g] = wr_merged;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg_q[g] <= synth_ctrl_pkg::REG_RESET[g];
      end else begin
        cfg_q[g] <= cfg_d[g];
      end
    end
  end

  // ---------------- field views ----------------
  assign ref_div_value = {cfg_q[synth_ctrl_pkg::IX_REFDIV_HI_OUTDIV][synth_ctrl_pkg::REFDIV_HI_LSB +: 2],
                          cfg_q[synth_ctrl_pkg::IX_REFDIV_LO]};
  assign prescale_value = {cfg_q[synth_ctrl_pkg::IX_PRESCALE_HI][3:0], cfg_q[synth_ctrl_pkg::IX_PRESCALE_LO]};
  assign output_div_value = cfg_q[synth_ctrl_pkg::IX_REFDIV_HI_OUTDIV][synth_ctrl_pkg::OUTDIV_LSB +: 4];
  assign dly_value = cfg_q[synth_ctrl_pkg::IX_CLK_GATE][synth_ctrl_pkg::DATA_CLK_DLY_LSB +: 3];
  assign clk_source_sel = cfg_q[synth_ctrl_pkg::IX_CLK_SOURCE][synth_ctrl_pkg::CLK_SOURCE_BIT];
  assign clk_gate_en = cfg_q[synth_ctrl_pkg::IX_CLK_GATE][synth_ctrl_pkg::CLK_GATE_BIT];
  assign pump_current_code = cfg_q[synth_ctrl_pkg::IX_PUMP][3:0];
  assign filter_resistor_code = cfg_q[synth_ctrl_pkg::IX_FILTER_RES][4:0];
  assign filter_cap_three_code = cfg_q[synth_ctrl_pkg::IX_FILTER_CAP3][4:0];
  assign filter_cap_one_code = cfg_q[synth_ctrl_pkg::IX_FILTER_CAP1][4:0];
  assign filter_cap_two_code = cfg_q[synth_ctrl_pkg::IX_FILTER_CAP2][4:0];
  assign synth_enable = cfg_q[synth_ctrl_pkg::IX_SYNTH_EN][synth_ctrl_pkg::SYNTH_EN_BIT];
  assign ref_divider_enable = cfg_q[synth_ctrl_pkg::IX_SYNTH_EN][synth_ctrl_pkg::REFDIV_EN_BIT];
  assign synth_out_enable = cfg_q[synth_ctrl_pkg::IX_OUT_EN][synth_ctrl_pkg::OUT_EN_BIT];
  assign synth_bias_enable = cfg_q[synth_ctrl_pkg::IX_OUT_EN][synth_ctrl_pkg::BIAS_EN_BIT];
  assign soft_reset_active = cfg_q[synth_ctrl_pkg::IX_SOFT_RESET][synth_ctrl_pkg::SOFT_RESET_BIT];

  // ---------------- calibration ----------------
  always_comb begin
    trig_change = wr_pend_q && wr_idx_q == synth_ctrl_pkg::IDX_W'(synth_ctrl_pkg::IX_CAL_TRIG)
      && (wr_byte[synth_ctrl_pkg::CAL_TRIG_BIT]
          != cfg_q[synth_ctrl_pkg::IX_CAL_TRIG][synth_ctrl_pkg::CAL_TRIG_BIT]);
    soft_exit = wr_pend_q && wr_idx_q == synth_ctrl_pkg::IDX_W'(synth_ctrl_pkg::IX_SOFT_RESET)
      && soft_reset_active && !wr_byte[synth_ctrl_pkg::SOFT_RESET_BIT];
    cal_start = trig_change || soft_exit;
    cal_state_d = cal_state_q;
    cal_cnt_d = cal_cnt_q;
    status_d = status_q;
    // a new trigger while running restarts the sequence
    if (cal_start) begin
      cal_state_d = synth_ctrl_pkg::CAL_RUN;
      cal_cnt_d = '0;
      status_d[synth_ctrl_pkg::STAT_CAL_DONE_BIT] = 1'b0;
    end else begin
      unique case (cal_state_q)
        synth_ctrl_pkg::CAL_IDLE: begin
          cal_cnt_d = '0;
        end
        synth_ctrl_pkg::CAL_RUN: begin
          if (cal_cnt_q == synth_ctrl_pkg::CAL_LAST) begin
            cal_state_d = synth_ctrl_pkg::CAL_IDLE;
            status_d[synth_ctrl_pkg::STAT_CAL_DONE_BIT] = 1'b1;
          end else begin
            cal_cnt_d = cal_cnt_q + 8'h01;
          end
        end
      endcase
    end
    status_d[synth_ctrl_pkg::STAT_DRIFT_LOW_BIT] = osc_drift_low_in;
    status_d[synth_ctrl_pkg::STAT_DRIFT_HIGH_BIT] = osc_drift_high_in;
    cal_busy_d = cal_state_d == synth_ctrl_pkg::CAL_RUN;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_state_q <= synth_ctrl_pkg::CAL_IDLE;
      cal_cnt_q <= '0;
      cal_busy <= 1'b0;
      status_q <= 8'h00;
    end else begin
      cal_state_q <= cal_state_d;
      cal_cnt_q <= cal_cnt_d;
      cal_busy <= cal_busy_d;
      status_q <= status_d;
    end
  end

  // ---------------- divider chain ----------------
  tick_divider #(.W(10)) u_ref_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(synth_enable && ref_divider_enable),
    .divisor(ref_div_value),
    .tick(ref_edge),
    .pulse_q(comparator_ref_pulse)
  );

  tick_divider #(.W(12)) u_fb_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(synth_enable),
    .divisor(prescale_value),
    .tick(osc_tick_in),
    .pulse_q(feedback_pulse)
  );

  tick_divider #(.W(4)) u_out_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(synth_enable && synth_out_enable),
    .divisor(output_div_value),
    .tick(osc_tick_in),
    .pulse_q(synth_pulse)
  );

  // ---------------- core clock select and data clock delay ----------------
  always_comb begin
    ref_edge = ref_clk_in && !ref_prev_q;
    gated_pulse = synth_pulse && clk_gate_en;
    core_sample_d = clk_source_sel ? gated_pulse : ref_edge;
    pump_bias_d = 9'(pump_current_code) * synth_ctrl_pkg::PUMP_STEP_UA;
    delay_cnt_d = delay_cnt_q;
    delay_run_d = delay_run_q;
    data_clock_d = 1'b0;
    if (gated_pulse) begin
      if (dly_value == 3'h0) begin
        data_clock_d = 1'b1;
        delay_run_d = 1'b0;
      end else begin
        delay_cnt_d = dly_value;
        delay_run_d = 1'b1;
      end
    end else if (delay_run_q && osc_tick_in) begin
      if (delay_cnt_q == 3'h1) begin
        data_clock_d = 1'b1;
        delay_run_d = 1'b0;
        delay_cnt_d = 3'h0;
      end else begin
        delay_cnt_d = delay_cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_prev_q <= 1'b0;
      core_sample_pulse <= 1'b0;
      output_data_clock <= 1'b0;
      delay_cnt_q <= 3'h0;
      delay_run_q <= 1'b0;
      pump_bias_ua <= 9'(synth_ctrl_pkg::REG_RESET[synth_ctrl_pkg::IX_PUMP][3:0]) * synth_ctrl_pkg::PUMP_STEP_UA;
    end else begin
      ref_prev_q <= ref_clk_in;
      core_sample_pulse <= core_sample_d;
      output_data_clock <= data_clock_d;
      delay_cnt_q <= delay_cnt_d;
      delay_run_q <= delay_run_d;
      pump_bias_ua <= pump_bias_d;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_unmapped_a: assert property (addr_take && !hwrite && !reg_hit && !stat_hit |=> hrdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");
  trig_launch_a: assert property (trig_change |=> cal_busy && cal_cnt_q == 8'h00)
    else $error("trigger toggle did not start calibration");
  soft_exit_cal_a: assert property (soft_exit |=> cal_busy ##1 !status_q[0])
    else $error("soft reset exit did not start calibration");
  cal_length_a: assert property ($fell(cal_busy) |-> $past(cal_cnt_q) == synth_ctrl_pkg::CAL_LAST
                                  && status_q[0])
    else $error("calibration ended at the wrong count or without done");
  drift_mirror_a: assert property (##1 status_q[2:1] == $past({osc_drift_high_in, osc_drift_low_in}))
    else $error("drift flags do not follow the monitors");
  direct_clock_a: assert property (!clk_source_sel && ref_clk_in && !ref_prev_q |=> core_sample_pulse)
    else $error("external clock edge not passed to core");
  gate_block_a: assert property (clk_source_sel && !clk_gate_en |=> !core_sample_pulse)
    else $error("synthesized clock passed while withheld");
  delay_zero_a: assert property (gated_pulse && dly_value == 3'h0 |=> output_data_clock)
    else $error("undelayed data clock missing");
  pump_scale_a: assert property (##1 pump_bias_ua == 9'(25 * $past(pump_current_code)))
    else $error("pump bias does not match code");
  status_ro_a: assert property (addr_take && hwrite && stat_hit |=> !wr_pend_q)
    else $error("write to status accepted");

endmodule : synth_clock_control

// ==== sim/synth_far_side.sv ====
// far-side model: reference clock, oscillator ticks, drift monitors
`timescale 1ns/1ps
module synth_far_side #(
  parameter int REF_HALF = 2,
  parameter int OSC_GAP = 2
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // drift levels asked for by the bench
  input wire logic [1:0] drift_sel,
  // toward the block
  output logic ref_clk_in,
  output logic osc_tick_in,
  output logic osc_drift_low_in,
  output logic osc_drift_high_in
);
  int ref_cnt;
  int osc_cnt;
  // 50 MHz reference against a 200 MHz bus clock
  // oscillator ticks stand for the tuned oscillator, scaled down
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt <= 0;
      osc_cnt <= 0;
      ref_clk_in <= 1'b0;
      osc_tick_in <= 1'b0;
    end else begin
      ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
      if (ref_cnt == REF_HALF - 1) ref_clk_in <= ~ref_clk_in;
      osc_cnt <= (osc_cnt == OSC_GAP - 1) ? 0 : osc_cnt + 1;
      osc_tick_in <= (osc_cnt == OSC_GAP - 1);
    end
  end
  assign osc_drift_low_in = drift_sel[0];
  assign osc_drift_high_in = drift_sel[1];
endmodule : synth_far_side

// ==== sim/synth_clock_control_tb_top.sv ====
// self-checking bench for the synthesizer control block
`timescale 1ns/1ps
module synth_clock_control_tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, trig;
  logic [11:0] haddr;
  logic [1:0] htrans, drift_sel;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic ref_clk_in, osc_tick_in, osc_drift_low_in, osc_drift_high_in;
  logic ref_prev = 1'b0;
  logic comparator_ref_pulse, feedback_pulse, core_sample_pulse, output_data_clock;
  logic [3:0] pump_current_code;
  logic [8:0] pump_bias_ua;
  logic [4:0] filter_resistor_code, filter_cap_one_code, filter_cap_two_code, filter_cap_three_code;
  logic synth_enable, ref_divider_enable, synth_out_enable, synth_bias_enable, soft_reset_active, cal_busy;
  logic [7:0] sh [256];
  int n_fail = 0;
  int tests_run = 0;
  int cnt [6] = '{default: 0};
  int d [6];

  assign hready = hreadyout;

  synth_clock_control DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hreadyout, .hrdata, .hresp,
    .ref_clk_in, .osc_tick_in, .osc_drift_low_in, .osc_drift_high_in,
    .comparator_ref_pulse, .feedback_pulse, .core_sample_pulse, .output_data_clock,
    .pump_current_code, .pump_bias_ua, .filter_resistor_code, .filter_cap_one_code,
    .filter_cap_two_code, .filter_cap_three_code, .synth_enable, .ref_divider_enable,
    .synth_out_enable, .synth_bias_enable, .soft_reset_active, .cal_busy
  );
  synth_far_side far (.hclk, .hresetn, .drift_sel, .ref_clk_in, .osc_tick_in, .osc_drift_low_in, .osc_drift_high_in);

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // edge and pulse counters
  always @(posedge hclk) begin
    ref_prev <= ref_clk_in;
    cnt[0] <= cnt[0] + int'(ref_clk_in & ~ref_prev);
    cnt[1] <= cnt[1] + int'(osc_tick_in);
    cnt[2] <= cnt[2] + int'(comparator_ref_pulse);
    cnt[3] <= cnt[3] + int'(feedback_pulse);
    cnt[4] <= cnt[4] + int'(core_sample_pulse);
    cnt[5] <= cnt[5] + int'(output_data_clock);
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic near(input int got, input int exp, input int tol, input string what);
    tests_run++;
    if (got > exp + tol || got < exp - tol) begin
      n_fail++;
      $display("wrong value at %0t: %s count %0d expected %0d", $time, what, got, exp);
    end
  endtask : near

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 100);
    if (hready !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: bus never ready", $time);
      tally_and_finish();
    end
  endtask : wait_rdy

  // one word transfer; byte address is four times the offset
  task automatic bus(input logic wr_en, input logic [7:0] ix, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {2'b00, ix, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr_en;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    wait_rdy();
    rd = hrdata;
    chk(hresp, 1'b0, "response");
  endtask : bus

  task automatic wr(input logic [7:0] ix, input logic [7:0] wd);
    bus(1'b1, ix, wd);
  endtask : wr

  task automatic rdc(input logic [7:0] ix, input logic [7:0] e, input string what);
    bus(1'b0, ix, 8'h00);
    chk(rd, {24'h000000, e}, what);
  endtask : rdc

  task automatic measure(input int cyc);
    int s [6];
    s = cnt;
    repeat (cyc) @(posedge hclk);
    foreach (d[i]) d[i] = cnt[i] - s[i];
  endtask : measure

  // len: edges still to pass until busy falls
  task automatic cal_check(input logic run, input int len);
    int n;
    n = 0;
    #1;
    chk(cal_busy, run, "cal start");
    while (cal_busy === 1'b1 && n < 1000) begin
      @(posedge hclk);
      #1;
      n++;
    end
    if (cal_busy === 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: calibration never ended", $time);
      tally_and_finish();
    end
    if (run) chk(n, len, "cal length");
    @(posedge hclk);
  endtask : cal_check

  task automatic clock_case(input logic [9:0] r, input logic [7:0] nn, input logic [3:0] od, input logic [2:0] dl);
    wr(8'h54, r[7:0]);
    wr(8'h55, {od, 2'b00, r[9:8]});
    wr(8'h56, nn);
    wr(8'h5A, (r > 10'h002) ? 8'h1F : 8'h07);
    wr(8'h57, 8'h00);
    wr(8'h6D, {5'h01, dl});
    trig = ~trig;
    wr(8'h6B, {7'h00, trig});
    cal_check(1'b1, synth_ctrl_pkg::CAL_CYCLES);
    measure(2400);
    near(d[2] * int'(r), d[0], int'(r), "ref divider");
    near(d[3] * int'(nn), d[1], int'(nn), "feedback");
    near(d[4] * int'(od), d[1], int'(od), "sample clock");
    near(d[5], d[4], 1, "data clock");
  endtask : clock_case

  initial begin
    logic [7:0] b;
    logic [7:0] v;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    drift_sel = 2'b00;
    trig = 1'b0;
    void'($urandom(47));
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < synth_ctrl_pkg::REG_COUNT; i++) begin
      b = synth_ctrl_pkg::REG_INDEX[i];
      sh[b] = synth_ctrl_pkg::REG_RESET[i];
      rdc(b, sh[b], "reset value");
    end
    measure(400);
    near(d[4], d[0], 1, "direct clock");
    $display("test reset done");
    for (int i = 0; i < synth_ctrl_pkg::REG_COUNT; i++) begin
      b = synth_ctrl_pkg::REG_INDEX[i];
      v = 8'($urandom());
      if (b != 8'h00 && b != 8'h6B) begin
        sh[b] = v & synth_ctrl_pkg::REG_WMASK[i];
        wr(b, v);
        rdc(b, sh[b], "readback");
      end
    end
    @(posedge hclk);
    chk(pump_bias_ua, 9'(sh[8'h58][3:0]) * 9'h019, "pump bias");
    chk(pump_current_code, sh[8'h58][3:0], "pump code");
    chk({filter_resistor_code, filter_cap_three_code, filter_cap_one_code, filter_cap_two_code},
        {sh[8'h5A][4:0], sh[8'h5B][4:0], sh[8'h5C][4:0], sh[8'h5D][4:0]}, "filter codes");
    chk({synth_enable, ref_divider_enable, synth_out_enable, synth_bias_enable},
        {sh[8'h59][0], sh[8'h59][1], sh[8'h5F][0], sh[8'h5F][1]}, "enables");
    wr(8'h60, 8'hFF);
    rdc(8'h60, 8'h00, "unmapped");
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      drift_sel <= 2'(k);
      repeat (4) @(posedge hclk);
      wr(8'hD1, 8'hFF);
      rdc(8'hD1, 8'(k << 1), "drift flags");
      rdc(8'hD1, 8'(k << 1), "status reread");
    end
    drift_sel <= 2'b00;
    repeat (4) @(posedge hclk);
    $display("test status done");
    wr(8'h6B, 8'h01);
    cal_check(1'b1, synth_ctrl_pkg::CAL_CYCLES);
    rdc(8'hD1, 8'h01, "cal done");
    wr(8'h6B, 8'h01);
    cal_check(1'b0, 0);
    wr(8'h6B, 8'h00);
    cal_check(1'b1, synth_ctrl_pkg::CAL_CYCLES);
    wr(8'h6B, 8'h01);
    repeat (50) @(posedge hclk);
    wr(8'h6B, 8'h00);
    cal_check(1'b1, synth_ctrl_pkg::CAL_CYCLES);
    wr(8'h00, 8'h01);
    cal_check(1'b0, 0);
    chk(soft_reset_active, 1'b1, "soft reset mode");
    wr(8'h00, 8'h00);
    @(posedge hclk);
    rdc(8'hD1, 8'h00, "done cleared");
    cal_check(1'b1, synth_ctrl_pkg::CAL_CYCLES - 3);
    rdc(8'hD1, 8'h01, "cal done again");
    $display("test calibration done");
    wr(8'h58, 8'h04);
    wr(8'h5A, 8'h07);
    wr(8'h59, 8'h03);
    wr(8'h5F, 8'h03);
    wr(8'h53, 8'h01);
    clock_case(10'h001, 8'h01, 4'h1, 3'h0);
    clock_case(10'($urandom_range(7, 2)), 8'($urandom_range(9, 2)), 4'($urandom_range(15, 8)), 3'h7);
    wr(8'h6D, 8'h00);
    wr(8'h59, 8'h01);
    repeat (40) @(posedge hclk);
    measure(400);
    near(d[4], 0, 0, "sample clock gated");
    near(d[5], 0, 0, "data clock gated");
    near(d[2], 0, 0, "ref divider off");
    $display("test clock path done");
    tally_and_finish();
  end
endmodule : synth_clock_control_tb_top
